// File: verilog/sct_pkg.sv
// Overview of operation
// (R1) The counter is a 16-bit up-counter fed by the clock divided by 1, 8 or 32.
// (R2) Writing 1 to the run bit starts counting and writing 0 stops it.
// (R3) In capture mode, writing the run bit to 0 clears the counter to zero.
// (R4) In capture mode the counter runs freely over 65536 counts, pulsing overflow.
// (R5) A valid trigger edge copies the counter into capture zero and pulses capture; the code does so only in capture mode with the run bit at 1.
// (R6) A two-bit edge-select field in control zero picks the valid trigger edge.
// (R7) With the filter on, a new pulse level counts after three equal samples.
// (R8) A two-bit field in control one enables the filter and picks its sample clock.
// (R9) Reads return the live count and the count latched at the latest capture.
// (R10) In capture mode, writes to the counter and to capture zero are ignored.
// (R11) Software changes clear-select and mode bits only while counting is stopped.
// (R12) In capture mode software keeps clear-select and compare-output bits at 0.
// (R13) In capture mode software sets compare one priority to zero, clears pending.
// (R14) Software accesses compare one only as one 16-bit access.
// (R15) In capture mode the four waveform pins are released, never driven.
// (R16) On overflow the counter wraps from its maximum to zero and keeps counting.
package sct_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [7:0] OFS_CNT    = 8'h00;
  localparam logic [7:0] OFS_CAP0   = 8'h04;
  localparam logic [7:0] OFS_CMP1   = 8'h08;
  localparam logic [7:0] OFS_CTRL0  = 8'h0C;
  localparam logic [7:0] OFS_CTRL1  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Control zero fields
  localparam int CR0_RUN     = 0;
  localparam int CR0_MODE    = 1;
  localparam int CR0_COUNTER_CLEAR_SELECT    = 2;
  localparam int CR0_EDGE_LO = 3;
  localparam int CR0_SRC_LO  = 5;
  localparam int CR0_TRIG    = 7;
  // Control one fields
  localparam int CR1_FILT_LO = 0;
  localparam int CR1_CMPO_LO = 4;
  // Status fields
  localparam int ST_RUN  = 0;
  localparam int ST_LVL  = 1;
  localparam int ST_CAPF = 2;
  localparam int ST_OVFF = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and encodings
  localparam logic [7:0]  CR0_RST   = 8'h00;
  localparam logic [7:0]  CR1_RST   = 8'h00;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic        MODE_CAP  = 1'h0;
  localparam logic [1:0]  EDGE_RISE = 2'h0;
  localparam logic [1:0]  EDGE_FALL = 2'h1;
  localparam logic [1:0]  SEL_DIV1  = 2'h0;
  localparam logic [1:0]  SEL_DIV8  = 2'h1;
  localparam logic [1:0]  FILT_OFF  = 2'h0;
  localparam logic [4:0]  MASK_DIV8  = 5'h07;
  localparam logic [4:0]  MASK_DIV32 = 5'h1F;
  localparam int          FILT_SAMPLES = 3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Divided tick from the free prescaler: 0 -> /1, 1 -> /8, else /32
  function automatic logic div_tick(input logic [1:0] sel,
                                    input logic [4:0] pre);
    logic t;
    t = 1'b0;
    case (sel)
      SEL_DIV1: t = 1'b1;
      SEL_DIV8: t = ((pre & MASK_DIV8) == MASK_DIV8);
      default:  t = (pre == MASK_DIV32);
    endcase
    return t;
  endfunction : div_tick

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  ws);
    logic [15:0] v;
    v = old;
    if (ws[0]) v[7:0]  = wd[7:0];
    if (ws[1]) v[15:8] = wd[15:8];
    return v;
  endfunction : lane_merge

endpackage : sct_pkg

// File: verilog/sct_filter.sv
`timescale 1ns/1ps
`default_nettype none
module sct_filter #(
  parameter int SAMPLES = 3
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Filter setup
  input  wire logic enable,
  input  wire logic sample_tick,
  // Level in and out
  input  wire logic din,
  output var  logic dout
);

  logic [SAMPLES-1:0] hist_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_r <= '0;
    end else if (ce && sample_tick) begin
      hist_r <= {hist_r[SAMPLES-2:0], din};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        dout <= din;
      end else if (&hist_r) begin // R7
        dout <= 1'b1;
      end else if (~|hist_r) begin // R7
        dout <= 1'b0;
      end
    end
  end

endmodule : sct_filter
`default_nettype wire

// File: verilog/sct_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sct_timer #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins
  input  wire logic              pulse_capture_input,
  input  wire logic              slow_capture_clock,
  output var  logic [3:0]        wave_out,
  output var  logic [3:0]        wave_out_oe,
  // Request pulses
  output var  logic              capture_irq_req,
  output var  logic              overflow_irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [15:0] timer_counter_r;
  logic [15:0] capture_compare_zero_r;
  logic [15:0] compare_one_r;
  logic [7:0]  control_reg_zero_r;
  logic [7:0]  control_reg_one_r;
  logic        cap_flag_r;
  logic        ovf_flag_r;
  logic [4:0]  pre_r;

  logic        count_run_bit;
  logic        capture_mode;
  logic [1:0]  edge_sel;
  logic [1:0]  src_sel;
  logic [1:0]  filt_sel;
  logic        cnt_tick;
  logic        filt_tick;

  assign count_run_bit = control_reg_zero_r[sct_pkg::CR0_RUN];
  assign capture_mode  =
    (control_reg_zero_r[sct_pkg::CR0_MODE] == sct_pkg::MODE_CAP);
  assign edge_sel  = control_reg_zero_r[sct_pkg::CR0_EDGE_LO +: 2];
  assign src_sel   = control_reg_zero_r[sct_pkg::CR0_SRC_LO +: 2];
  assign filt_sel  = control_reg_one_r[sct_pkg::CR1_FILT_LO +: 2];
  assign cnt_tick  = sct_pkg::div_tick(src_sel, pre_r); // R1
  assign filt_tick = sct_pkg::div_tick(filt_sel - 2'h1, pre_r); // R8

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  logic              aw_full_r;
  logic              w_full_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              wr_go;
  logic              wr_known;

  assign s_axi_awready = ce && !aw_full_r;
  assign s_axi_wready  = ce && !w_full_r;
  assign wr_go         = ce && aw_full_r && w_full_r && !s_axi_bvalid;

  always_comb begin
    case (aw_addr_r[7:0])
      sct_pkg::OFS_CNT,   sct_pkg::OFS_CAP0,  sct_pkg::OFS_CMP1,
      sct_pkg::OFS_CTRL0, sct_pkg::OFS_CTRL1, sct_pkg::OFS_STATUS:
        wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sct_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? sct_pkg::RESP_OKAY : sct_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_at(input logic [7:0] ofs);
    return wr_go && (aw_addr_r[7:0] == ofs);
  endfunction : wr_at

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic ctrl0_wr;
  logic stop_clear;

  assign ctrl0_wr   = wr_at(sct_pkg::OFS_CTRL0) && w_strb_r[0];
  assign stop_clear = ctrl0_wr && !w_data_r[sct_pkg::CR0_RUN] &&
                      (w_data_r[sct_pkg::CR0_MODE] == sct_pkg::MODE_CAP);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg_zero_r <= sct_pkg::CR0_RST;
      control_reg_one_r  <= sct_pkg::CR1_RST;
      compare_one_r      <= sct_pkg::CNT_RST;
    end else if (ce) begin
      if (ctrl0_wr) begin
        control_reg_zero_r <= w_data_r[7:0]; // R2 R6
      end
      if (wr_at(sct_pkg::OFS_CTRL1) && w_strb_r[0]) begin
        control_reg_one_r <= w_data_r[7:0]; // R8
      end
      if (wr_at(sct_pkg::OFS_CMP1)) begin
        compare_one_r <= sct_pkg::lane_merge(compare_one_r, w_data_r,
                                             w_strb_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 5'h00;
    end else if (ce) begin
      pre_r <= pre_r + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_counter_r <= sct_pkg::CNT_RST;
    end else if (ce) begin
      if (wr_at(sct_pkg::OFS_CNT) && !capture_mode) begin // R10
        timer_counter_r <= sct_pkg::lane_merge(timer_counter_r, w_data_r,
                                               w_strb_r);
      end else if (stop_clear) begin
        timer_counter_r <= sct_pkg::CNT_RST; // R3
      end else if (count_run_bit && cnt_tick) begin
        timer_counter_r <= timer_counter_r + 16'h0001; // R1 R4 R16
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_irq_req <= 1'b0;
    end else if (ce) begin
      overflow_irq_req <= count_run_bit && cnt_tick && !stop_clear &&
                          (timer_counter_r == sct_pkg::CNT_MAX); // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, filter, edge detect
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] sync3_r;
  logic [1:0] pin_lvl_r;
  logic       filt_lvl;
  logic       trig_lvl;
  logic       trig_prev_r;
  logic       edge_hit;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r   <= 2'h0;
      sync2_r   <= 2'h0;
      sync3_r   <= 2'h0;
      pin_lvl_r <= 2'h0;
    end else if (ce) begin
      sync1_r <= {slow_capture_clock, pulse_capture_input};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < 2; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          pin_lvl_r[i] <= sync3_r[i];
        end
      end
    end
  end

  sct_filter #(
    .SAMPLES     (sct_pkg::FILT_SAMPLES)
  ) u_filter (
    .clk         (ref_clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .enable      (filt_sel != sct_pkg::FILT_OFF),
    .sample_tick (filt_tick),
    .din         (pin_lvl_r[0]),
    .dout        (filt_lvl)
  );

  assign trig_lvl = control_reg_zero_r[sct_pkg::CR0_TRIG] ? pin_lvl_r[1]
                                                          : filt_lvl;

  always_comb begin
    case (edge_sel) // R6
      sct_pkg::EDGE_RISE: edge_hit = trig_lvl && !trig_prev_r;
      sct_pkg::EDGE_FALL: edge_hit = !trig_lvl && trig_prev_r;
      default:            edge_hit = trig_lvl != trig_prev_r;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_r <= 1'b0;
    end else if (ce) begin
      trig_prev_r <= trig_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture register and request
  logic cap_evt;

  assign cap_evt = capture_mode && count_run_bit && edge_hit;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_compare_zero_r <= sct_pkg::CNT_RST;
      capture_irq_req        <= 1'b0;
    end else if (ce) begin
      capture_irq_req <= cap_evt; // R5
      if (cap_evt) begin
        capture_compare_zero_r <= timer_counter_r; // R5
      end else if (wr_at(sct_pkg::OFS_CAP0) && !capture_mode) begin // R10
        capture_compare_zero_r <=
          sct_pkg::lane_merge(capture_compare_zero_r, w_data_r, w_strb_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear, set wins
  logic [1:0] st_clr;

  assign st_clr = (wr_at(sct_pkg::OFS_STATUS) && w_strb_r[0]) ?
                  {w_data_r[sct_pkg::ST_OVFF], w_data_r[sct_pkg::ST_CAPF]}
                  : 2'h0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_flag_r <= 1'b0;
      ovf_flag_r <= 1'b0;
    end else if (ce) begin
      cap_flag_r <= (cap_flag_r && !st_clr[0]) || capture_irq_req;
      ovf_flag_r <= (ovf_flag_r && !st_clr[1]) || overflow_irq_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform pins, released in capture mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_out    <= 4'h0;
      wave_out_oe <= 4'h0;
    end else if (ce) begin
      wave_out    <= 4'h0;
      wave_out_oe <= capture_mode ? 4'h0 // R15
                     : control_reg_one_r[sct_pkg::CR1_CMPO_LO +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  logic [31:0] rd_mux;
  logic        rd_known;

  always_comb begin
    rd_mux   = 32'h0000_0000;
    rd_known = 1'b1;
    case (s_axi_araddr[7:0])
      sct_pkg::OFS_CNT:    rd_mux[15:0] = timer_counter_r; // R9
      sct_pkg::OFS_CAP0:   rd_mux[15:0] = capture_compare_zero_r; // R9
      sct_pkg::OFS_CMP1:   rd_mux[15:0] = compare_one_r;
      sct_pkg::OFS_CTRL0:  rd_mux[7:0]  = control_reg_zero_r;
      sct_pkg::OFS_CTRL1:  rd_mux[7:0]  = control_reg_one_r;
      sct_pkg::OFS_STATUS: rd_mux[3:0]  =
        {ovf_flag_r, cap_flag_r, filt_lvl, count_run_bit};
      default:             rd_known     = 1'b0;
    endcase
  end

  assign s_axi_arready = ce && !s_axi_rvalid;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= sct_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_known ? sct_pkg::RESP_OKAY : sct_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : sct_timer
`default_nettype wire

// File: test/sct_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sct_timer_chk #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              arst_n,
  input wire logic              ce,
  // Register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Pins and requests
  input wire logic              pulse_capture_input,
  input wire logic              slow_capture_clock,
  input wire logic [3:0]        wave_out,
  input wire logic [3:0]        wave_out_oe,
  input wire logic              capture_irq_req,
  input wire logic              overflow_irq_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [ADDR_W-1:0] aw_q;
  logic              wm_q, mode_q, p_q, s_q;
  logic [16:0]       gap_q;
  logic [7:0]        chg_q;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {aw_q, wm_q, mode_q, p_q, s_q, gap_q, chg_q} <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wm_q <= s_axi_wdata[1];
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 &&
          aw_q[7:0] == sct_pkg::OFS_CTRL0) mode_q <= wm_q;
      p_q <= pulse_capture_input;
      s_q <= slow_capture_clock;
      if (overflow_irq_req || mode_q) gap_q <= '0;
      else if (gap_q != 17'h1FFFF) gap_q <= gap_q + 17'h00001;
      if (p_q != pulse_capture_input || s_q != slow_capture_clock)
        chg_q <= '0;
      else if (chg_q != 8'hFF) chg_q <= chg_q + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_WAVE_LOW: assert property (wave_out == 4'h0)
    else $error("wave high");
  AST_OE_CAP: assert property (!mode_q && !$past(mode_q) |->
    wave_out_oe == 4'h0) else $error("pins driven");
  AST_CAP_CAUSE: assert property (capture_irq_req |-> chg_q < 8'd200)
    else $error("stray capture");
  AST_OVF_GAP: assert property (overflow_irq_req |->
    gap_q >= 17'd65535) else $error("early overflow");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no rvalid");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read overlap");
  AST_WR_ANS: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready ##1 ce |=> s_axi_bvalid)
    else $error("no bvalid");
  COV_CAP: cover property (capture_irq_req);
  COV_OVF: cover property (overflow_irq_req);
  COV_WR: cover property (s_axi_bvalid && s_axi_bready);
  COV_RD: cover property (s_axi_rvalid && s_axi_rready);
endmodule : sct_timer_chk
bind sct_timer sct_timer_chk #(.ADDR_W(ADDR_W)) sct_timer_chk_inst (.*);
`default_nettype wire

// File: test/sct_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
module sct_pulse_src (
  // Clock and commands
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [7:0] hi_len,
  input  wire logic       slow_en,
  // Pins
  output var  logic       pulse,
  output var  logic       slow
);
  logic [7:0] left;
  logic [4:0] div;
  initial begin
    {pulse, slow, left, div} = '0;
  end
  // High pulse of hi_len cycles per fire
  always @(posedge clk) begin
    if (fire) begin
      pulse <= 1'b1;
      left  <= hi_len - 8'h01;
    end else if (left != 8'h00) left <= left - 8'h01;
    else pulse <= 1'b0;
  end
  // Slow clock toggles every 32 cycles, stands still when off
  always @(posedge clk) begin
    if (slow_en) begin
      div <= div + 5'h01;
      if (div == 5'h1F) slow <= ~slow;
    end
  end
endmodule : sct_pulse_src
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk, arst_n, ce, fire, slow_en;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, capture_irq_req;
  logic        pulse_capture_input, slow_capture_clock, overflow_irq_req;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, hi_len;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, wave_out, wave_out_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          fail_count, num_checks, cap_n, ovf_n, cyc;
  sct_timer #(.ADDR_W(8)) sct_timer_inst (.*);
  sct_pulse_src sct_pulse_src_inst (.clk(ref_clk), .fire(fire),
    .hi_len(hi_len), .slow_en(slow_en), .pulse(pulse_capture_input),
    .slow(slow_capture_clock));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (capture_irq_req === 1'b1) cap_n <= cap_n + 1;
    if (overflow_irq_req === 1'b1) ovf_n <= ovf_n + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic wo(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] x = 2'h0);
    logic       ta, tw, dn;
    logic [1:0] r;
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int k = 0; k < 100; k++) begin
      @(negedge ref_clk);
      {ta, tw, dn, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid,
                         s_axi_bresp};
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (dn) s_axi_bready <= 1'b0;
      if (dn) break;
    end
    if (!dn) fail_count++;
    chk(32'(r), 32'(x));
  endtask : wo
  task automatic ro(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] x = 2'h0);
    logic       ta, dn;
    logic [1:0] r;
    @(posedge ref_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (int k = 0; k < 100; k++) begin
      @(negedge ref_clk);
      {ta, dn, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata,
                        s_axi_rresp};
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (dn) s_axi_rready <= 1'b0;
      if (dn) break;
    end
    if (!dn) fail_count++;
    chk(32'(r), 32'(x));
  endtask : ro
  task automatic start(input logic [7:0] c);
    wo(sct_pkg::OFS_CTRL0, 32'h0);
    wo(sct_pkg::OFS_CTRL0, {24'h0, c});
  endtask : start
  task automatic pulse(input logic [7:0] n);
    @(posedge ref_clk);
    hi_len <= n;
    fire   <= 1'b1;
    @(posedge ref_clk);
    fire   <= 1'b0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      ro(8'(i * 4), d);
      chk(d, 32'h0);
    end
    wo(8'h18, 32'h1, sct_pkg::RESP_SLVERR);
    ro(8'h18, d, sct_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_count;
    logic [31:0] d;
    int          dv;
    for (int s = 0; s < 3; s++) begin
      dv = (s == 0) ? 1 : (s == 1) ? 8 : 32;
      start(8'h01 | 8'(s << 5));
      tick(320);
      ro(sct_pkg::OFS_CNT, d);
      chk(32'(d >= 320 / dv && d <= 332 / dv + 1), 32'h1);
    end
    wo(sct_pkg::OFS_CTRL0, 32'h0);
    ro(sct_pkg::OFS_CNT, d);
    chk(d, 32'h0);
    tick(20);
    ro(sct_pkg::OFS_CNT, d);
    chk(d, 32'h0);
    wo(sct_pkg::OFS_CTRL0, 32'h2);
    wo(sct_pkg::OFS_CNT, 32'h0000ABCD);
    ro(sct_pkg::OFS_CNT, d);
    chk(d, 32'h0000ABCD);
    $display("test count done");
  endtask : t_count
  task automatic t_capture;
    logic [31:0] v1, v2;
    int          c, xr;
    for (int e = 0; e < 4; e++) begin
      start(8'h01 | 8'(e << 3));
      c = cap_n;
      pulse(8'd40);
      tick(10);
      ro(sct_pkg::OFS_CAP0, v1);
      tick(50);
      ro(sct_pkg::OFS_CAP0, v2);
      if (e == 0) xr = int'(v1);
      chk(32'(cap_n - c), (e >= 2) ? 32'h2 : 32'h1);
      chk(v1, 32'(xr));
      chk(v2, 32'(xr + ((e > 0) ? 40 : 0)));
    end
    chk(32'(xr > 0 && xr < 20), 32'h1);
    $display("test capture done");
  endtask : t_capture
  task automatic t_filter;
    int c;
    for (int f = 0; f < 4; f++) begin
      wo(sct_pkg::OFS_CTRL1, 32'(f));
      start(8'h11);
      tick(100);
      c = cap_n;
      pulse(8'd2);
      tick(150);
      chk(32'(cap_n - c), (f > 0) ? 32'h0 : 32'h2);
      pulse(8'd200);
      tick(350);
      chk(32'(cap_n - c), (f > 0) ? 32'h2 : 32'h4);
    end
    wo(sct_pkg::OFS_CTRL1, 32'h0);
    $display("test filter done");
  endtask : t_filter
  task automatic t_slow;
    int c;
    start(8'h81);
    c = cap_n;
    @(posedge ref_clk);
    slow_en <= 1'b1;
    pulse(8'd30);
    tick(330);
    slow_en <= 1'b0;
    tick(10);
    chk(32'(cap_n - c), 32'h5);
    $display("test slow trigger done");
  endtask : t_slow
  task automatic t_write_ign;
    logic [31:0] v1, d;
    start(8'h01);
    ro(sct_pkg::OFS_CAP0, v1);
    wo(sct_pkg::OFS_CNT, 32'h0000FFFF);
    wo(sct_pkg::OFS_CAP0, 32'h00001234);
    ro(sct_pkg::OFS_CAP0, d);
    chk(d, v1);
    ro(sct_pkg::OFS_CNT, d);
    chk(32'(d < 32'h100), 32'h1);
    wo(sct_pkg::OFS_CMP1, 32'h0000A5C3);
    ro(sct_pkg::OFS_CMP1, d);
    chk(d, 32'h0000A5C3);
    ro(sct_pkg::OFS_STATUS, d);
    chk(32'(d[sct_pkg::ST_RUN]), 32'h1);
    $display("test write ignore done");
  endtask : t_write_ign
  task automatic t_overflow;
    logic [31:0] d;
    int          t0;
    start(8'h01);
    t0 = cyc;
    for (int k = 0; k < 70000; k++) begin
      @(negedge ref_clk);
      if (overflow_irq_req === 1'b1) break;
    end
    chk(32'(cyc - t0 >= 65530 && cyc - t0 <= 65540), 32'h1);
    ro(sct_pkg::OFS_CNT, d);
    chk(32'(d < 32'h20), 32'h1);
    chk(32'(ovf_n), 32'h1);
    $display("test overflow done");
  endtask : t_overflow
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, fire, slow_en} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, hi_len} = 24'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_count;
    t_capture;
    t_filter;
    t_slow;
    t_write_ign;
    t_overflow;
    summarize;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    summarize;
  end
endmodule : tb_top
`default_nettype wire
